// ===== rtl/ext_mem_bus_cycle.sv
// Purpose: Two-phase multiplexed external memory bus cycle
// Assumes: One ref_clk cycle per phase, wait sampled on rising edge
// Notes: Strobes low across a whole phase cycle
// Functional notes
// - Each access is one address phase then one data phase
// - Address driven in address phase, high byte port holds until next address phase
// - Read floats low port in data phase, data sampled at strobe rise
// - Write data driven in data phase and held until next address
// - Data strobe goes low only for external accesses
// - Address strobe low for the whole address phase of external accesses
// - Data strobe low during data phase of external upper-block accesses
// - Strobes and read/write float on bus acknowledge or float bit
// - Address and data strobes held high in reset
// - Block bit selects upper block on data strobe, lower on second strobe
// - Second data strobe stays high for internal accesses
// - Read/write high for read, low for write, stable through cycle
// - Second strobe and read/write drive only when enabled as alternate function
// - Read/write pin goes to weak pull-up in reset
// - Variant without program memory resets into external mode with waits
// - Low address byte multiplexed with data, high byte on second port
// - Enabled wait input adds one cycle per active sample
`include "ext_mem_regs.svh"
module ext_mem_bus_cycle (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic no_internal_program_memory,
    input wire logic req_valid,
    input ext_mem_pkg::mem_req_t req,
    input wire logic bus_ack,
    input wire logic bus_float_bit,
    input wire logic wait_input_enable,
    input wire logic wait_n,
    input wire logic lower_af_en,
    input wire logic rw_af_en,
    input wire logic [7:0] ad_in,
    output logic req_ready,
    output logic rdata_valid,
    output logic [7:0] rdata,
    output logic ext_mem_iface,
    output logic [7:0] ad_out,
    output logic [7:0] ad_oe,
    output logic [7:0] addr_hi_out,
    output ext_mem_pkg::strobe_t pin_out,
    output ext_mem_pkg::strobe_t pin_oe,
    output logic rw_pullup
);
    ext_mem_pkg::cycle_state_t state, next_state;
    ext_mem_pkg::mem_req_t cur, next_cur;
    ext_mem_pkg::strobe_t strobes, next_strobes;
    logic next_req_ready, next_rdata_valid, next_ext_mem_iface;
    logic [7:0] next_rdata, next_ad_out, next_ad_oe, next_addr_hi_out;
    logic [3:0] boot_waits, next_boot_waits;
    logic strap_done, next_strap_done;
    logic stretch;

    function automatic logic wait_hit(input logic en, input logic w_n, input logic [3:0] bw);
        return (en & ~w_n) | (bw != 4'h0);
    endfunction

    // ============================================
    // Cycle sequencer
    always_comb begin
        next_state = state;
        next_cur = cur;
        next_strobes = strobes;
        next_req_ready = 1'b0;
        next_rdata_valid = 1'b0;
        next_rdata = rdata;
        next_ad_out = ad_out;
        next_ad_oe = ad_oe;
        next_addr_hi_out = addr_hi_out;
        next_ext_mem_iface = ext_mem_iface;
        next_boot_waits = boot_waits;
        next_strap_done = 1'b1;
        stretch = wait_hit(wait_input_enable, wait_n, boot_waits);
        if (!strap_done && no_internal_program_memory) begin
            next_ext_mem_iface = 1'b1;
        end
        case (state)
            ext_mem_pkg::st_idle: begin
                next_strobes = '{default: 1'b1};
                next_strobes.rw = strobes.rw;
                if (req_valid && !bus_ack) begin
                    next_cur = req;
                    next_state = ext_mem_pkg::st_addr;
                    next_strobes.rw = ~req.write;
                    next_ad_out = req.addr[7:0];
                    next_ad_oe = 8'hff;
                    next_addr_hi_out = req.addr[15:8];
                    next_strobes.addr_strobe_n = ~req.external;
                    if (no_internal_program_memory) begin
                        next_boot_waits = `EMB_BOOT_WAITS;
                    end
                end
            end
            ext_mem_pkg::st_addr: begin
                if (stretch) begin
                    if (boot_waits != 4'h0) begin
                        next_boot_waits = boot_waits - 4'h1;
                    end
                end else begin
                    next_state = ext_mem_pkg::st_data;
                    next_strobes.addr_strobe_n = 1'b1;
                    if (cur.write) begin
                        next_ad_out = cur.wdata;
                    end else begin
                        next_ad_oe = 8'h00;
                    end
                    if (cur.external) begin
                        next_strobes.data_strobe_n = ~cur.block_sel;
                        next_strobes.lower_block_strobe_n = cur.block_sel;
                    end
                    if (no_internal_program_memory) begin
                        next_boot_waits = `EMB_BOOT_WAITS;
                    end
                end
            end
            ext_mem_pkg::st_data: begin
                if (stretch) begin
                    if (boot_waits != 4'h0) begin
                        next_boot_waits = boot_waits - 4'h1;
                    end
                end else begin
                    next_state = ext_mem_pkg::st_idle;
                    next_strobes.data_strobe_n = 1'b1;
                    next_strobes.lower_block_strobe_n = 1'b1;
                    next_req_ready = 1'b1;
                    if (!cur.write) begin
                        next_rdata = ad_in;
                        next_rdata_valid = 1'b1;
                    end
                end
            end
            default: next_state = ext_mem_pkg::st_idle;
        endcase
        if (srst) begin
            next_state = ext_mem_pkg::st_idle;
            next_strobes = '{default: 1'b1};
            next_ad_oe = 8'h00;
            next_ad_out = 8'h00;
            next_addr_hi_out = 8'h00;
            next_rdata = 8'h00;
            next_req_ready = 1'b0;
            next_rdata_valid = 1'b0;
            next_ext_mem_iface = `EMB_PORT_MODE_RST;
            next_boot_waits = 4'h0;
            next_strap_done = 1'b0;
            next_cur = '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        state <= next_state;
        cur <= next_cur;
        strobes <= next_strobes;
        req_ready <= next_req_ready;
        rdata_valid <= next_rdata_valid;
        rdata <= next_rdata;
        ad_out <= next_ad_out;
        ad_oe <= next_ad_oe;
        addr_hi_out <= next_addr_hi_out;
        ext_mem_iface <= next_ext_mem_iface;
        boot_waits <= next_boot_waits;
        strap_done <= next_strap_done;
    end

    // ============================================
    // Pin stage
    pin_drive u_pin_drive (
        .ref_clk(ref_clk),
        .srst(srst),
        .float_req(bus_ack | bus_float_bit),
        .lower_af_en(lower_af_en),
        .rw_af_en(rw_af_en),
        .strobes(strobes),
        .pin_out(pin_out),
        .pin_oe(pin_oe),
        .rw_pullup(rw_pullup)
    );

    // ============================================
    // Checks
    addr_to_data_a: assert property (@(posedge ref_clk) disable iff (srst)
        state == ext_mem_pkg::st_addr && !stretch |=> state == ext_mem_pkg::st_data)
        else $error("Address phase not followed by data phase");
    addr_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
        state == ext_mem_pkg::st_data |-> $stable(addr_hi_out))
        else $error("High address moved in data phase");
    read_float_a: assert property (@(posedge ref_clk) disable iff (srst)
        state == ext_mem_pkg::st_data && !cur.write |-> ad_oe == 8'h00)
        else $error("Low port driven during read data phase");
    write_drive_a: assert property (@(posedge ref_clk) disable iff (srst)
        state == ext_mem_pkg::st_data && cur.write |-> ad_oe == 8'hff && ad_out == cur.wdata)
        else $error("Write data not driven");
    internal_ds_a: assert property (@(posedge ref_clk) disable iff (srst)
        !cur.external |-> strobes.data_strobe_n && strobes.lower_block_strobe_n)
        else $error("Data strobe low on internal access");
    as_phase_a: assert property (@(posedge ref_clk) disable iff (srst)
        !strobes.addr_strobe_n |-> state == ext_mem_pkg::st_addr)
        else $error("Address strobe outside address phase");
    block_sel_a: assert property (@(posedge ref_clk) disable iff (srst)
        !strobes.lower_block_strobe_n |-> !cur.block_sel && strobes.data_strobe_n)
        else $error("Lower strobe on upper block");
    float_a: assert property (@(posedge ref_clk) disable iff (srst)
        bus_ack |=> pin_oe == '0)
        else $error("Pins driven during acknowledge");
    rw_stable_a: assert property (@(posedge ref_clk) disable iff (srst)
        state == ext_mem_pkg::st_data |-> strobes.rw == ~cur.write)
        else $error("Read/write level wrong");
    reset_high_a: assert property (@(posedge ref_clk)
        srst |=> pin_out.addr_strobe_n && pin_out.data_strobe_n && rw_pullup)
        else $error("Strobes not high in reset");
    wait_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
        state == ext_mem_pkg::st_data && stretch |=> state == ext_mem_pkg::st_data)
        else $error("Wait did not stretch");
    read_c: cover property (@(posedge ref_clk) rdata_valid);
    write_c: cover property (@(posedge ref_clk) state == ext_mem_pkg::st_data && cur.write);
    wait_c: cover property (@(posedge ref_clk) state == ext_mem_pkg::st_addr && stretch);
endmodule

// ===== rtl/ext_mem_pkg.sv
// Purpose: Types for the external memory bus cycle block
// Assumes: Constants come from ext_mem_regs.svh
// Notes: None
`include "ext_mem_regs.svh"
package ext_mem_pkg;
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_addr = 2'b01,
        st_data = 2'b11
    } cycle_state_t;

    typedef struct packed {
        logic [`EMB_ADDR_W-1:0] addr;
        logic [`EMB_DATA_W-1:0] wdata;
        logic write;
        logic external;
        logic block_sel;
    } mem_req_t;

    typedef struct packed {
        logic addr_strobe_n;
        logic data_strobe_n;
        logic lower_block_strobe_n;
        logic rw;
    } strobe_t;
endpackage

// ===== rtl/ext_mem_regs.svh
// Purpose: Constants for the external memory bus cycle block
// Assumes: 25 MHz ref_clk
// Notes: Included by the package users
`ifndef EXT_MEM_REGS_SVH
`define EXT_MEM_REGS_SVH
`define EMB_ADDR_W 16
`define EMB_DATA_W 8
`define EMB_BLOCK_BIT 5
`define EMB_PORT_MODE_RST 1'b0
`define EMB_BOOT_WAITS 4'h3
`endif

// ===== rtl/pin_drive.sv
// Purpose: Output stage for strobes and read/write pin
// Assumes: Strobe values registered upstream
// Notes: Floats pins on acknowledge or float bit
module pin_drive (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic float_req,
    input wire logic lower_af_en,
    input wire logic rw_af_en,
    input ext_mem_pkg::strobe_t strobes,
    output ext_mem_pkg::strobe_t pin_out,
    output ext_mem_pkg::strobe_t pin_oe,
    output logic rw_pullup
);
    ext_mem_pkg::strobe_t next_pin_out;
    ext_mem_pkg::strobe_t next_pin_oe;
    logic next_rw_pullup;

    // ============================================
    // Drive and float
    always_comb begin
        next_pin_out = strobes;
        next_pin_oe = '{default: ~float_req};
        next_pin_oe.lower_block_strobe_n = ~float_req & lower_af_en;
        next_pin_oe.rw = ~float_req & rw_af_en;
        next_rw_pullup = 1'b0;
        if (srst) begin
            next_pin_out = '{default: 1'b1};
            next_pin_oe = '0;
            next_rw_pullup = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        pin_out <= next_pin_out;
        pin_oe <= next_pin_oe;
        rw_pullup <= next_rw_pullup;
    end
endmodule

// ===== verification/ext_mem_model.sv
// Purpose: External ROM and RAM model on the multiplexed bus
// Assumes: Read data is the high address byte xor 5a
// Notes: Low port reads back a toggling pattern while the device drives it
module ext_mem_model (
    input wire logic ref_clk,
    input ext_mem_pkg::strobe_t pin_out,
    input wire logic [7:0] ad_out,
    input wire logic [7:0] ad_oe,
    input wire logic [7:0] addr_hi_out,
    output logic [7:0] ad_in,
    output logic [7:0] last_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] prev = 8'h00;
    // ==========================================
    // Read data while the device releases the port
    assign ad_in = (ad_oe == 8'h00) ? (addr_hi_out ^ 8'h5a) : ~prev;
    always @(posedge ref_clk) begin
        prev <= ad_in;
        // Write data captured while a data strobe is low
        if ((!pin_out.data_strobe_n || !pin_out.lower_block_strobe_n) && ad_oe == 8'hff) begin
            last_wdata <= ad_out;
        end
    end
endmodule

// ===== verification/test_ext_mem_bus_cycle.sv
// Purpose: Self-checking bench for the bus cycle block
// Assumes: Answer 2 edges after take, pins lag one cycle
// Notes: Rows cover read, write, both blocks, internal
module test_ext_mem_bus_cycle;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, srst = 1, strap = 0, req_valid = 0, bus_ack = 0, bus_float_bit = 0;
    logic wait_input_enable = 0, wait_n = 1, lower_af_en = 1, rw_af_en = 1;
    ext_mem_pkg::mem_req_t req = '0;
    logic req_ready, rdata_valid, ext_mem_iface, rw_pullup, ds, lds, rwl, gotv;
    logic [7:0] ad_in, rdata, ad_out, ad_oe, addr_hi_out, last_wdata, rd;
    ext_mem_pkg::strobe_t pin_out, pin_oe;
    int mismatches = 0, samples_checked = 0, cycles = 0, lat;
    ext_mem_pkg::mem_req_t rows[6] = '{'{16'h12a0, 8'h00, 0, 1, 1}, '{16'h3455, 8'hc3, 1, 1, 1},
        '{16'h56aa, 8'h00, 0, 1, 0}, '{16'h7801, 8'h3c, 1, 1, 0},
        '{16'h9a10, 8'h00, 0, 0, 1}, '{16'hbc20, 8'h77, 1, 0, 0}};
    logic [7:0] exp_rd[6] = '{8'h48, 8'h00, 8'h0c, 8'h00, 8'h00, 8'h00};
    always #20 ref_clk = ~ref_clk;
    ext_mem_bus_cycle DUT (.ref_clk(ref_clk), .srst(srst), .no_internal_program_memory(strap),
        .req_valid(req_valid), .req(req), .bus_ack(bus_ack), .bus_float_bit(bus_float_bit),
        .wait_input_enable(wait_input_enable), .wait_n(wait_n), .lower_af_en(lower_af_en),
        .rw_af_en(rw_af_en), .ad_in(ad_in), .req_ready(req_ready), .rdata_valid(rdata_valid),
        .rdata(rdata), .ext_mem_iface(ext_mem_iface), .ad_out(ad_out), .ad_oe(ad_oe),
        .addr_hi_out(addr_hi_out), .pin_out(pin_out), .pin_oe(pin_oe), .rw_pullup(rw_pullup));
    ext_mem_model mem (.ref_clk(ref_clk), .pin_out(pin_out), .ad_out(ad_out), .ad_oe(ad_oe),
        .addr_hi_out(addr_hi_out), .ad_in(ad_in), .last_wdata(last_wdata));
    // ==========================================
    // Checking and closing
    task check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            stop_test;
        end
    end
    // ==========================================
    // One bus cycle with pin watching
    task sample;
        ds |= (pin_out.data_strobe_n === 1'b0);
        lds |= (pin_out.lower_block_strobe_n === 1'b0);
        rwl |= (pin_out.addr_strobe_n === 1'b0 && pin_out.rw === 1'b0);
        if (rdata_valid === 1'b1) begin
            gotv = 1;
            rd = rdata;
        end
    endtask
    task run(input ext_mem_pkg::mem_req_t r, input int w);
        lat = 0; ds = 0; lds = 0; rwl = 0; gotv = 0;
        req = r;
        req_valid = 1;
        wait_n = (w == 0);
        do begin
            @(posedge ref_clk);
            #1;
            lat++;
            if (lat == w) wait_n = 1;
            sample();
        end while (req_ready !== 1'b1 && lat < 40);
        req_valid = 0;
        repeat (3) begin
            @(posedge ref_clk);
            #1;
            sample();
        end
    endtask
    // ==========================================
    // Main sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        #1;
        check({pin_out.addr_strobe_n, pin_out.data_strobe_n, rw_pullup}, 16'h0007);
        check(pin_oe, 16'h0000);
        srst = 0;
        for (int i = 0; i < 6; i++) begin
            run(rows[i], 0);
            check(16'(lat), 16'h0003);
            check(ds, rows[i].external && rows[i].block_sel);
            check(lds, rows[i].external && !rows[i].block_sel);
            if (rows[i].external) check(rwl, rows[i].write);
            if (rows[i].external && !rows[i].write) check({gotv, rd}, {8'h01, exp_rd[i]});
            if (rows[i].external && rows[i].write) check(last_wdata, rows[i].wdata);
        end
        wait_input_enable = 1;
        run(rows[0], 2);
        check(16'(lat), 16'h0004);
        wait_input_enable = 0;
        lower_af_en = 0;
        rw_af_en = 0;
        repeat (2) @(posedge ref_clk);
        #1;
        check({pin_oe.lower_block_strobe_n, pin_oe.rw}, 16'h0000);
        bus_float_bit = 1;
        repeat (2) @(posedge ref_clk);
        #1;
        check(pin_oe, 16'h0000);
        bus_float_bit = 0;
        bus_ack = 1;
        repeat (2) @(posedge ref_clk);
        #1;
        check(pin_oe, 16'h0000);
        bus_ack = 0;
        lower_af_en = 1;
        rw_af_en = 1;
        repeat (2) @(posedge ref_clk);
        #1;
        check(pin_oe, 16'h000f);
        strap = 1;
        srst = 1;
        repeat (20) @(posedge ref_clk);
        #1;
        srst = 0;
        repeat (3) @(posedge ref_clk);
        #1;
        check(ext_mem_iface, 1'b1);
        run(rows[0], 0);
        check(16'(lat), 16'h0009);
        check({gotv, rd}, {8'h01, exp_rd[0]});
        stop_test;
    end
endmodule
